// file: hdl/irq_vec_pkg.sv
// constants and types for the interrupt arbitration and vectoring block
`default_nettype none
package irq_vec_pkg;
   localparam int          NUM_SRC        = 23;
   localparam logic [4:0]  EXT_ZERO_ORDER = 5'h00;
   localparam logic [4:0]  EXT_ONE_ORDER  = 5'h02;
   localparam logic [4:0]  CONV_ORDER     = 5'h0A;
   localparam logic [4:0]  WARN_ORDER     = 5'h0F;
   localparam logic [4:0]  OSC_FAIL_ORDER = 5'h11;
   localparam logic [15:0] RESET_VECTOR   = 16'h0000;
   localparam logic [15:0] VECTOR_BASE    = 16'h0003;
   localparam logic [15:0] VECTOR_STEP    = 16'h0008;
   localparam int          DETECT_CYCLES  = 1;
   localparam int          LCALL_CYCLES   = 5;
   localparam int          BEST_LATENCY   = 7;
   localparam int          WORST_LATENCY  = 19;
   localparam logic [1:0]  LVL_NONE       = 2'h0;
   localparam logic [1:0]  LVL_LOW        = 2'h1;
   localparam logic [1:0]  LVL_HIGH       = 2'h2;
   typedef enum logic [1:0] {SEQ_RUN, SEQ_HOLD, SEQ_CALL} seq_state_e;

   // fixed vector address from arbitration order
   function automatic logic [15:0] vector_of(input logic [4:0] order);
      vector_of = VECTOR_BASE + 16'({order, 3'b000});
   endfunction
endpackage
`default_nettype wire

// file: hdl/irq_pick.sv
// fixed-order picker: lowest set index wins
`default_nettype none
module irq_pick #(
   parameter int N = 23
) (
   // candidates
   input  wire logic [N-1:0] req_i,
   // result
   output logic              any_o,
   output logic [4:0]        idx_o
);
   always_comb begin
      any_o = 1'b0;
      idx_o = 5'h00;
      for (int i = N - 1; i >= 0; i--) begin
         if (req_i[i]) begin
            any_o = 1'b1;
            idx_o = 5'(i);
         end
      end
   end
endmodule
`default_nettype wire

// file: hdl/irq_vectoring.sv
// interrupt arbitration, vectoring and response sequencing
// Operation
// - arbitrate every clock, sample the winner every clock outside a call
// - best response: detect, one instruction, call
// - after return, one instruction before call
// - worst response nineteen clocks, with divide
// - equal or lower request waits for return
// - fixed vectors and orders, reset outranks
// - external zero flag cleared on vectoring
// - external one cleared; others left alone
// - supply warning flags read-only, gate by enable
// - oscillator-fail flag feeds order seventeen
// - nothing requested unless global enable set
// - high preempts low, high never preempted
// - still-pending flag re-enters after return
// - higher level wins, then lower order
`default_nettype none
module irq_vectoring
   import irq_vec_pkg::*;
#(
   parameter int N = irq_vec_pkg::NUM_SRC
) (
   // clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         arst_n_i,
   // peripheral pending flags, order 0..N-1
   input  wire logic [N-1:0] src_pending_i,
   input  wire logic         lf_osc_fail_pending_i,
   // external request pins, edge or level detected by caller
   input  wire logic         external_request_zero_i,
   input  wire logic         external_request_one_i,
   // software writes to the external flags
   input  wire logic         ext_zero_sw_clr_i,
   input  wire logic         ext_one_sw_clr_i,
   // enables and priorities
   input  wire logic         global_irq_enable_i,
   input  wire logic [N-1:0] src_enable_i,
   input  wire logic [N-1:0] src_high_i,
   // instruction sequencer
   input  wire logic         instr_done_i,
   input  wire logic         reti_done_i,
   input  wire logic         lcall_done_i,
   // to sequencer
   output logic              irq_request_o,
   output logic              lcall_start_o,
   output logic [15:0]       vector_addr_o,
   output logic [4:0]        vector_order_o,
   output logic [1:0]        active_level_o,
   // flags seen by software
   output logic              ext_zero_pending_o,
   output logic              ext_one_pending_o,
   output logic [N-1:0]      pending_o
);
   import irq_vec_pkg::*;

   logic          ext_zero_pending_reg;
   logic          ext_one_pending_reg;
   logic [N-1:0]  pend;
   logic [N-1:0]  req_all;
   logic [N-1:0]  req_hi;
   logic [N-1:0]  req_lo;
   logic          hi_any;
   logic          lo_any;
   logic [4:0]    hi_idx;
   logic [4:0]    lo_idx;
   logic          cand;
   logic [4:0]    cand_idx;
   logic          cand_high;
   logic          win_reg;
   logic [4:0]    win_idx_reg;
   logic          win_high_reg;
   logic          vectoring;
   logic          after_reti_reg;
   logic          in_high_reg;
   logic          in_low_reg;
   logic          low_saved_reg;
   seq_state_e    state_reg;
   logic [15:0]   vector_addr_reg;
   logic [4:0]    vector_order_reg;

   // set wins over clear for the external flags
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ext_zero_pending_reg <= 1'b0;
         ext_one_pending_reg  <= 1'b0;
      end else begin
         if (external_request_zero_i)
            ext_zero_pending_reg <= 1'b1;
         else if (ext_zero_sw_clr_i || (vectoring && win_idx_reg == EXT_ZERO_ORDER))
            ext_zero_pending_reg <= 1'b0;
         if (external_request_one_i)
            ext_one_pending_reg <= 1'b1;
         else if (ext_one_sw_clr_i || (vectoring && win_idx_reg == EXT_ONE_ORDER))
            ext_one_pending_reg <= 1'b0;
      end
   end

   always_comb begin
      pend = src_pending_i;
      pend[EXT_ZERO_ORDER] = ext_zero_pending_reg;
      pend[EXT_ONE_ORDER]  = ext_one_pending_reg;
      pend[OSC_FAIL_ORDER] = src_pending_i[OSC_FAIL_ORDER] | lf_osc_fail_pending_i;
   end

   // warning flags cannot be cleared here; only the enable masks them
   assign req_all = global_irq_enable_i ? (pend & src_enable_i) : '0;
   // high routine blocks all, low routine blocks low
   assign req_hi  = in_high_reg ? '0 : (req_all & src_high_i);
   assign req_lo  = (in_high_reg || in_low_reg) ? '0 : (req_all & ~src_high_i);

   irq_pick #(.N(N)) u_pick_hi (
      .req_i (req_hi),
      .any_o (hi_any),
      .idx_o (hi_idx)
   );

   irq_pick #(.N(N)) u_pick_lo (
      .req_i (req_lo),
      .any_o (lo_any),
      .idx_o (lo_idx)
   );

   always_comb begin
      cand      = hi_any | lo_any;
      cand_high = hi_any;
      cand_idx  = hi_any ? hi_idx : lo_idx;
   end

   // one detect cycle: winner registered every clock in SEQ_RUN, held during SEQ_CALL
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         win_reg      <= 1'b0;
         win_idx_reg  <= 5'h00;
         win_high_reg <= 1'b0;
      end else if (state_reg == SEQ_RUN) begin
         win_reg      <= cand;
         win_idx_reg  <= cand_idx;
         win_high_reg <= cand_high;
      end
   end

   // a return arms a one-instruction hold before any call
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         after_reti_reg <= 1'b0;
      else if (reti_done_i)
         after_reti_reg <= 1'b1;
      else if (instr_done_i)
         after_reti_reg <= 1'b0;
   end

   // call issued at the end of the current instruction
   assign vectoring = (state_reg == SEQ_RUN) && win_reg && cand && instr_done_i
                      && !after_reti_reg && !reti_done_i;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= SEQ_RUN;
      end else begin
         case (state_reg)
            SEQ_RUN: begin
               if (vectoring)
                  state_reg <= SEQ_CALL;
            end
            SEQ_CALL: begin
               if (lcall_done_i)
                  state_reg <= SEQ_RUN;
            end
            default: begin
               state_reg <= SEQ_RUN;
            end
         endcase
      end
   end

   // service levels in progress; low resumes after a preempting high
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         in_high_reg   <= 1'b0;
         in_low_reg    <= 1'b0;
         low_saved_reg <= 1'b0;
      end else if (vectoring) begin
         if (win_high_reg) begin
            in_high_reg   <= 1'b1;
            low_saved_reg <= in_low_reg;
         end else begin
            in_low_reg <= 1'b1;
         end
      end else if (reti_done_i) begin
         if (in_high_reg) begin
            in_high_reg <= 1'b0;
            in_low_reg  <= low_saved_reg;
         end else begin
            in_low_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         vector_addr_reg  <= RESET_VECTOR;
         vector_order_reg <= 5'h00;
      end else if (vectoring) begin
         vector_addr_reg  <= vector_of(win_idx_reg);
         vector_order_reg <= win_idx_reg;
      end
   end

   assign irq_request_o      = win_reg && cand && (state_reg == SEQ_RUN);
   assign lcall_start_o      = vectoring;
   assign vector_addr_o      = vector_addr_reg;
   assign vector_order_o     = vector_order_reg;
   assign active_level_o     = in_high_reg ? LVL_HIGH : (in_low_reg ? LVL_LOW : LVL_NONE);
   assign ext_zero_pending_o = ext_zero_pending_reg;
   assign ext_one_pending_o  = ext_one_pending_reg;
   assign pending_o          = pend;
endmodule
`default_nettype wire

// file: bench/irq_vectoring_sva.sv
// assertions on the vectoring block ports
`default_nettype none
module irq_vectoring_sva
   import irq_vec_pkg::*;
#(parameter int N = 23) (
   // clock, reset and controls
   input wire logic         sys_clk_i, arst_n_i, global_irq_enable_i,
   input wire logic         instr_done_i, reti_done_i, external_request_zero_i,
   input wire logic [N-1:0] src_high_i,
   // outputs watched
   input wire logic         irq_request_o, lcall_start_o, ext_zero_pending_o,
   input wire logic [15:0]  vector_addr_o,
   input wire logic [4:0]   vector_order_o,
   input wire logic [1:0]   active_level_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_call; lcall_start_o; endsequence
   sequence s_reti_instr; reti_done_i ##1 instr_done_i; endsequence
   chk_call_cause: assert property (s_call |-> instr_done_i && irq_request_o)
      else $error("call without request");
   chk_global_gate: assert property (!global_irq_enable_i |-> !irq_request_o)
      else $error("request while disabled");
   chk_call_gap: assert property (s_call |=> !lcall_start_o [*4])
      else $error("call restarted");
   chk_hold_reti: assert property (s_reti_instr |-> !lcall_start_o)
      else $error("call right after return");
   chk_vector_addr: assert property (s_call |=> vector_addr_o == 16'h0003 + {8'h00, vector_order_o, 3'b000})
      else $error("vector address wrong");
   chk_order_still: assert property (!$past(lcall_start_o) |-> $stable(vector_order_o))
      else $error("order moved without call");
   chk_zero_clr: assert property (s_call ##1 vector_order_o == 5'h00 |-> !ext_zero_pending_o
      || $past(external_request_zero_i)) else $error("ext zero flag kept");
   chk_level_set: assert property (s_call |=> active_level_o == (src_high_i[vector_order_o] ? LVL_HIGH : LVL_LOW))
      else $error("level wrong");
endmodule
bind irq_vectoring irq_vectoring_sva #(.N(N)) u_sva (.sys_clk_i, .arst_n_i, .global_irq_enable_i, .instr_done_i,
   .reti_done_i, .external_request_zero_i, .src_high_i, .irq_request_o, .lcall_start_o, .ext_zero_pending_o,
   .vector_addr_o, .vector_order_o, .active_level_o);
`default_nettype wire

// file: bench/seq_model.sv
// sequencer stand-in: single-cycle instructions, call and return
`default_nettype none
module seq_model (
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   input  wire logic lcall_start_i,
   input  wire logic ret_req_i,
   output logic      instr_done_o,
   output logic      reti_done_o,
   output logic      lcall_done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt_reg;
   logic       ret_reg;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_reg <= 3'h0;
         ret_reg <= 1'b0;
      end else if (lcall_start_i) begin
         cnt_reg <= 3'h5;
      end else if (ret_req_i && cnt_reg == 3'h0) begin
         cnt_reg <= 3'h5;
         ret_reg <= 1'b1;
      end else if (cnt_reg != 3'h0) begin
         cnt_reg <= cnt_reg - 3'h1;
         ret_reg <= ret_reg && cnt_reg != 3'h1;
      end
   end
   assign instr_done_o = cnt_reg == 3'h0;
   assign lcall_done_o = cnt_reg == 3'h1 && !ret_reg;
   assign reti_done_o  = cnt_reg == 3'h1 && ret_reg;
endmodule
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the vectoring block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import irq_vec_pkg::*;
   logic sys_clk_i = 0, arst_n_i = 0, ea = 0, x0 = 0, x1 = 0, osc = 0, ret_req = 0;
   logic [22:0] pend = '0, en = '1, hi = '0;
   logic instr_done, reti_done, lcall_done, req, start, p0, p1;
   logic [15:0] va;
   logic [4:0] vo;
   logic [1:0] lvl;
   int n_errors = 0, checks = 0, t, a, b, w;
   irq_vectoring dut (.sys_clk_i, .arst_n_i, .src_pending_i(pend), .lf_osc_fail_pending_i(osc),
      .external_request_zero_i(x0), .external_request_one_i(x1), .ext_zero_sw_clr_i(1'b0),
      .ext_one_sw_clr_i(1'b0), .global_irq_enable_i(ea), .src_enable_i(en), .src_high_i(hi),
      .instr_done_i(instr_done), .reti_done_i(reti_done), .lcall_done_i(lcall_done), .irq_request_o(req),
      .lcall_start_o(start), .vector_addr_o(va), .vector_order_o(vo), .active_level_o(lvl),
      .ext_zero_pending_o(p0), .ext_one_pending_o(p1), .pending_o());
   seq_model seq (.clk_i(sys_clk_i), .arst_n_i, .lcall_start_i(start), .ret_req_i(ret_req),
      .instr_done_o(instr_done), .reti_done_o(reti_done), .lcall_done_o(lcall_done));
   always #25 sys_clk_i = ~sys_clk_i;
   // high level first, then lowest order
   function automatic int winner(logic [22:0] p, logic [22:0] h);
      winner = -1;
      for (int i = 22; i >= 0; i--) if (p[i] && (winner < 0 || h[i] || !h[winner])) winner = i;
   endfunction
   task automatic tick(int n = 1);
      repeat (n) begin @(posedge sys_clk_i); #2; end
   endtask
   task automatic chk(string s, logic [15:0] e, logic [15:0] g);
      checks++;
      if (g !== e) begin n_errors++; $display("MISMATCH %s expected %h seen %h", s, e, g); end
   endtask
   task automatic conclude();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // take the call and check the vector; ends one cycle after the call starts
   task automatic take(int o);
      for (t = 0; t < 40 && start !== 1'b1; t++) tick();
      tick();
      chk("vector", 16'h0003 + 16'(o * 8), va);
      chk("order", 16'(o), 16'(vo));
      pend[o] = 0;
      if (o == 17) osc = 0;
   endtask
   // issue a return; ends in the return's last cycle
   task automatic give_back();
      ret_req = 1; tick(); ret_req = 0;
      for (t = 0; t < 20 && reti_done !== 1'b1; t++) tick();
   endtask
   task automatic serve(int o);
      take(o);
      tick(5); give_back();
   endtask
   initial begin #200000; n_errors++; conclude(); end
   initial begin
      void'($urandom(32'h568EC689));
      tick(12); arst_n_i = 1; tick();
      chk("reset vector", 16'h0000, va);
      chk("reset level", 16'(LVL_NONE), 16'(lvl));
      ea = 1; pend[5] = 1;
      for (t = 0; t < 4 && start !== 1'b1; t++) tick();
      chk("detect cycles", 16'h1, 16'(t));
      serve(5); tick(2); ea = 0; pend[10] = 1; tick(10);
      chk("held request", 16'h0, 16'(req));
      ea = 1; serve(10); tick(2); x0 = 1; tick(); x0 = 0;
      serve(0); chk("ext zero flag", 16'h0, 16'(p0));
      tick(2); x1 = 1; tick(); x1 = 0;
      serve(2); chk("ext one flag", 16'h0, 16'(p1));
      // high request preempts a running low routine, low resumes after
      hi = '0; hi[4] = 1; tick(2); pend[3] = 1;
      take(3); chk("low level", 16'(LVL_LOW), 16'(lvl));
      tick(5); pend[4] = 1;
      take(4); chk("high level", 16'(LVL_HIGH), 16'(lvl));
      tick(5); give_back(); tick();
      chk("resumed level", 16'(LVL_LOW), 16'(lvl));
      give_back(); tick();
      chk("idle level", 16'(LVL_NONE), 16'(lvl));
      for (int k = 0; k < 16; k++) begin
         tick(2);
         a = 3 + $urandom % 20;
         b = 3 + (a - 2 + $urandom % 19) % 20;
         hi = 23'($urandom);
         if (a == 17) osc = 1; else pend[a] = 1;
         pend[b] = 1;
         w = winner(pend | (23'(osc) << 17), hi);
         serve(w);
         for (t = 0; t < 6 && start !== 1'b1; t++) tick();
         chk("reentry cycles", 16'h2, 16'(t));
         serve(w == a ? b : a);
      end
      conclude();
   end
endmodule
`default_nettype wire
